// ==== verilog/oltc_pkg.sv ====
// package: register map, commands and defaults of the output level and trigger control block
//
// Functional notes
// - up/down command moves the selected immediate voltage by exactly the step size
// - default keyword and reset load the minimum resolution into the step size
// - step query gives stored step; default query gives minimum resolution
// - each output has a pending triggered level, copied only on trigger
// - immediate voltage writes never change the pending triggered level
// - triggered level query returns immediate level until one is programmed
// - protection on and peak above trip level fires crowbar and latches trip
// - protection enable bit is on after reset, reads 0 off, 1 on
// - tripped status reads 1 while latch set and uncleared, else 0
// - clear drops the latch, restores pre-trip output, keeps trip level
// - one range bit per output, low or high, low after reset
// - range query reports the model's low or high range identifier
// - trigger source bus or immediate, volatile, bus after reset
// - trigger delay applies to bus source only, ignored for immediate
// - initiate with immediate source completes a full trigger at once
// - initiate with bus source only arms; bus trigger acts after delay
// - delay 0 to 3600 seconds, min and max map to limits, reset 0
// - software trigger and group execute trigger act alike on selected output
// - wait command stalls further commands until pending trigger completes
// - on completion, opc query puts 1 in output buffer; opc sets event bit 0
// - coupled outputs transfer both pending levels on one trigger; reset uncouples
package oltc_pkg;
   // ==========================================================================
   // register offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_VOLT   = 8'h04;
   localparam logic [7:0] OFF_VTRIG  = 8'h08;
   localparam logic [7:0] OFF_STEP   = 8'h0c;
   localparam logic [7:0] OFF_PLEVEL = 8'h10;
   localparam logic [7:0] OFF_DELAY  = 8'h14;
   localparam logic [7:0] OFF_CMD    = 8'h18;
   localparam logic [7:0] OFF_STAT   = 8'h1c;
   localparam logic [7:0] OFF_OBUF   = 8'h20;
   localparam logic [7:0] OFF_ESR    = 8'h24;
   // ==========================================================================
   // field positions
   localparam int CTRL_SEL    = 0;
   localparam int CTRL_COUPLE = 1;
   localparam int CTRL_SRCIMM = 2;
   localparam int CTRL_GUARD  = 3;
   localparam int CTRL_RANGE  = 4;
   localparam int ST_TRIP     = 0;
   localparam int ST_ARMED    = 1;
   localparam int ST_BUSY     = 2;
   localparam int ST_OBUFV    = 3;
   localparam int ST_RID_LO   = 4;
   localparam int ESR_OPC     = 0;
   // ==========================================================================
   // commands, written to the command register low nibble
   typedef enum logic [3:0] {
      OLTC_OP_NOP     = 4'h0,
      OLTC_OP_UP      = 4'h1,
      OLTC_OP_DOWN    = 4'h2,
      OLTC_OP_STEPDEF = 4'h3,
      OLTC_OP_STEPQD  = 4'h4,
      OLTC_OP_INIT    = 4'h5,
      OLTC_OP_TRG     = 4'h6,
      OLTC_OP_CLEAR   = 4'h7,
      OLTC_OP_WAI     = 4'h8,
      OLTC_OP_OPC     = 4'h9,
      OLTC_OP_OPCQ    = 4'ha,
      OLTC_OP_RST     = 4'hb,
      OLTC_OP_DLYMIN  = 4'hc,
      OLTC_OP_DLYMAX  = 4'hd
   } oltc_op_t;
   // ==========================================================================
   // range identifiers (encodings arbitrary)
   localparam logic [1:0] LOW_RANGE_ID_A  = 2'h0;
   localparam logic [1:0] HIGH_RANGE_ID_A = 2'h1;
   localparam logic [1:0] LOW_RANGE_ID_B  = 2'h2;
   localparam logic [1:0] HIGH_RANGE_ID_B = 2'h3;
   // ==========================================================================
   // levels and timing
   localparam int          VW          = 24;
   localparam int          LSB_UV      = 10;
   localparam int          MIN_RES_UV  = 380;
   localparam logic [23:0] STEP_DEF    = 24'(MIN_RES_UV / LSB_UV);
   localparam logic [23:0] VOLT_RST    = 24'h000000;
   localparam logic [23:0] PLEVEL_RST  = 24'h21a2e0;
   localparam int          DW          = 12;
   localparam logic [11:0] DELAY_MIN_S = 12'h000;
   localparam logic [11:0] DELAY_MAX_S = 12'he10;
   localparam int          TICK_S      = 1;
   localparam int          CLK_HZ      = 200000000;
   localparam int          TICK_CYC    = CLK_HZ * TICK_S;
endpackage : oltc_pkg

// ==== verilog/oltc_top.sv ====
// module: output level, protection and trigger control behind an AHB-Lite slave
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module oltc_top #(
   parameter int          TICK_CYCLES = oltc_pkg::TICK_CYC,
   parameter bit          MODEL_B     = 1'b0,
   parameter logic [23:0] VMAX        = 24'hffffff
) (
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic [31:0]                  hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   input  wire logic                    group_trigger,
   input  wire logic [oltc_pkg::VW-1:0] peak_v0,
   input  wire logic [oltc_pkg::VW-1:0] peak_v1,
   output logic [oltc_pkg::VW-1:0]      out_set_v0,
   output logic [oltc_pkg::VW-1:0]      out_set_v1,
   output logic [1:0]                   crowbar_switch,
   output logic [1:0]                   range_high
);
   import oltc_pkg::*;

   // ==========================================================================
   // bus slave
   logic            ph_wr_q, ph_rd_q;
   logic [7:0]      ph_addr_q;
   logic            stall;
   logic            wr_fire, rd_fire;
   logic            acc;

   assign acc = hsel && htrans[1] && hready;
   assign hresp = 1'b0;
   assign hreadyout = !stall;
   assign wr_fire = ph_wr_q && !stall;
   assign rd_fire = ph_rd_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_q   <= 1'b0;
         ph_rd_q   <= 1'b0;
         ph_addr_q <= 8'h00;
      end else if (!stall) begin
         ph_wr_q   <= acc && hwrite;
         ph_rd_q   <= acc && !hwrite;
         ph_addr_q <= haddr[7:0];
      end
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : hit

   // ==========================================================================
   // command decode
   oltc_op_t  op;
   logic      cmd_we;
   logic      soft_rst;
   logic      fire;
   logic      busy_q;
   logic      armed_q;
   logic      wai_q;
   logic      sel_q, couple_q, srcimm_q;
   logic [1:0] gt_sync_q;
   logic       gt_prev_q;
   logic       bus_trg;

   assign cmd_we   = wr_fire && hit(ph_addr_q, OFF_CMD);
   assign op       = oltc_op_t'(hwdata[3:0]);
   assign soft_rst = cmd_we && op == OLTC_OP_RST;
   // a command arriving while a wait is outstanding holds the bus
   assign stall    = ph_wr_q && hit(ph_addr_q, OFF_CMD) && wai_q && busy_q;

   // group execute trigger pin, synchronised then edge detected
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gt_sync_q <= 2'b00;
         gt_prev_q <= 1'b0;
      end else begin
         gt_sync_q <= {gt_sync_q[0], group_trigger};
         gt_prev_q <= gt_sync_q[1];
      end
   end
   assign bus_trg = (cmd_we && op == OLTC_OP_TRG) || (gt_sync_q[1] && !gt_prev_q);

   // ==========================================================================
   // global configuration
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_q    <= 1'b0;
         couple_q <= 1'b0;
         srcimm_q <= 1'b0;
      end else if (soft_rst) begin
         sel_q    <= 1'b0;
         couple_q <= 1'b0;
         srcimm_q <= 1'b0;
      end else if (wr_fire && hit(ph_addr_q, OFF_CTRL)) begin
         sel_q    <= hwdata[CTRL_SEL];
         couple_q <= hwdata[CTRL_COUPLE];
         srcimm_q <= hwdata[CTRL_SRCIMM];
      end
   end

   // ==========================================================================
   // trigger delay, seconds tick and arm state
   logic [DW-1:0] delay_q, cnt_q;
   logic [31:0]   div_q;
   logic          tick;
   logic          init_cmd;

   assign init_cmd = cmd_we && op == OLTC_OP_INIT;
   assign tick     = div_q == 32'(TICK_CYCLES - 1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         delay_q <= DELAY_MIN_S;
      end else if (soft_rst) begin
         delay_q <= DELAY_MIN_S;
      end else if (cmd_we && op == OLTC_OP_DLYMIN) begin
         delay_q <= DELAY_MIN_S;
      end else if (cmd_we && op == OLTC_OP_DLYMAX) begin
         delay_q <= DELAY_MAX_S;
      end else if (wr_fire && hit(ph_addr_q, OFF_DELAY)) begin
         // out of range values clamp to the maximum
         delay_q <= (hwdata[31:DW] != '0 || hwdata[DW-1:0] > DELAY_MAX_S)
                    ? DELAY_MAX_S : hwdata[DW-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         armed_q <= 1'b0;
         busy_q  <= 1'b0;
         cnt_q   <= '0;
         div_q   <= 32'h00000000;
      end else if (soft_rst) begin
         armed_q <= 1'b0;
         busy_q  <= 1'b0;
         cnt_q   <= '0;
         div_q   <= 32'h00000000;
      end else if (busy_q) begin
         div_q <= tick ? 32'h00000000 : div_q + 32'h00000001;
         if (cnt_q == '0) begin
            busy_q <= 1'b0;
         end else if (tick) begin
            cnt_q <= cnt_q - DW'(1);
         end
      end else if (init_cmd && !srcimm_q) begin
         armed_q <= 1'b1;
      end else if (bus_trg && armed_q && !srcimm_q) begin
         armed_q <= 1'b0;
         busy_q  <= 1'b1;
         cnt_q   <= delay_q;
         div_q   <= 32'h00000000;
      end
   end
   // unarmed or immediate-source bus triggers fall through and do nothing
   assign fire = (busy_q && cnt_q == '0) || (init_cmd && srcimm_q);

   // ==========================================================================
   // wait and operation complete
   logic       opc_wait_q, opcq_wait_q;
   logic [7:0] esr_q;
   logic [31:0] obuf_q;
   logic        obuf_v_q;
   logic        done;

   assign done = !busy_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wai_q <= 1'b0;
      end else if (soft_rst) begin
         wai_q <= 1'b0;
      end else if (cmd_we && op == OLTC_OP_WAI) begin
         wai_q <= 1'b1;
      end else if (done) begin
         wai_q <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opc_wait_q <= 1'b0;
         esr_q      <= 8'h00;
      end else if (soft_rst) begin
         opc_wait_q <= 1'b0;
         esr_q      <= 8'h00;
      end else begin
         opc_wait_q <= (opc_wait_q || (cmd_we && op == OLTC_OP_OPC)) && !done;
         if ((opc_wait_q || (cmd_we && op == OLTC_OP_OPC)) && done) begin
            esr_q[ESR_OPC] <= 1'b1;
         end else if (rd_fire && hit(ph_addr_q, OFF_ESR)) begin
            esr_q <= 8'h00;
         end
      end
   end

   // output buffer: loaded by queries, emptied by reading it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opcq_wait_q <= 1'b0;
         obuf_q      <= 32'h00000000;
         obuf_v_q    <= 1'b0;
      end else if (soft_rst) begin
         opcq_wait_q <= 1'b0;
         obuf_q      <= 32'h00000000;
         obuf_v_q    <= 1'b0;
      end else begin
         opcq_wait_q <= (opcq_wait_q || (cmd_we && op == OLTC_OP_OPCQ)) && !done;
         if ((opcq_wait_q || (cmd_we && op == OLTC_OP_OPCQ)) && done) begin
            obuf_q   <= 32'h00000001;
            obuf_v_q <= 1'b1;
         end else if (cmd_we && op == OLTC_OP_STEPQD) begin
            obuf_q   <= {8'h00, STEP_DEF};
            obuf_v_q <= 1'b1;
         end else if (rd_fire && hit(ph_addr_q, OFF_OBUF)) begin
            obuf_v_q <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // per-output level, protection and range state
   logic [VW-1:0] vimm_q [2];
   logic [VW-1:0] vtrig_q [2];
   logic [VW-1:0] step_q [2];
   logic [VW-1:0] plevel_q [2];
   logic [1:0]    tprog_q, guard_q, trip_q, range_q;
   logic [VW-1:0] peak_s1_q [2];
   logic [VW-1:0] peak_s2_q [2];
   logic [VW-1:0] peak_in [2];

   assign peak_in[0] = peak_v0;
   assign peak_in[1] = peak_v1;

   generate
      for (genvar g = 0; g < 2; g++) begin : g_out
         logic tgt;
         logic wsel;
         logic [VW:0] up_sum;
         assign wsel   = sel_q == 1'(g);
         assign tgt    = wsel || couple_q;
         assign up_sum = {1'b0, vimm_q[g]} + {1'b0, step_q[g]};

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               peak_s1_q[g] <= '0;
               peak_s2_q[g] <= '0;
            end else begin
               peak_s1_q[g] <= peak_in[g];
               peak_s2_q[g] <= peak_s1_q[g];
            end
         end

         // immediate level
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               vimm_q[g] <= VOLT_RST;
            end else if (soft_rst) begin
               vimm_q[g] <= VOLT_RST;
            end else if (fire && tgt) begin
               vimm_q[g] <= tprog_q[g] ? vtrig_q[g] : vimm_q[g];
            end else if (wsel && wr_fire && hit(ph_addr_q, OFF_VOLT)) begin
               vimm_q[g] <= hwdata[VW-1:0];
            end else if (wsel && cmd_we && op == OLTC_OP_UP) begin
               // a step past the top is refused, level stays
               if (up_sum <= {1'b0, VMAX}) begin
                  vimm_q[g] <= up_sum[VW-1:0];
               end
            end else if (wsel && cmd_we && op == OLTC_OP_DOWN) begin
               if (vimm_q[g] >= step_q[g]) begin
                  vimm_q[g] <= vimm_q[g] - step_q[g];
               end
            end
         end

         // pending triggered level, untouched by immediate writes
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               vtrig_q[g] <= VOLT_RST;
               tprog_q[g] <= 1'b0;
            end else if (soft_rst) begin
               vtrig_q[g] <= VOLT_RST;
               tprog_q[g] <= 1'b0;
            end else if (wsel && wr_fire && hit(ph_addr_q, OFF_VTRIG)) begin
               vtrig_q[g] <= hwdata[VW-1:0];
               tprog_q[g] <= 1'b1;
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               step_q[g] <= STEP_DEF;
            end else if (soft_rst) begin
               step_q[g] <= STEP_DEF;
            end else if (wsel && cmd_we && op == OLTC_OP_STEPDEF) begin
               step_q[g] <= STEP_DEF;
            end else if (wsel && wr_fire && hit(ph_addr_q, OFF_STEP)) begin
               step_q[g] <= hwdata[VW-1:0];
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               plevel_q[g] <= PLEVEL_RST;
               guard_q[g]  <= 1'b1;
               range_q[g]  <= 1'b0;
            end else if (soft_rst) begin
               plevel_q[g] <= PLEVEL_RST;
               guard_q[g]  <= 1'b1;
               range_q[g]  <= 1'b0;
            end else begin
               if (wsel && wr_fire && hit(ph_addr_q, OFF_PLEVEL)) begin
                  plevel_q[g] <= hwdata[VW-1:0];
               end
               if (wsel && wr_fire && hit(ph_addr_q, OFF_CTRL)) begin
                  guard_q[g] <= hwdata[CTRL_GUARD];
                  range_q[g] <= hwdata[CTRL_RANGE];
               end
            end
         end

         // trip latch: an overvoltage seen during a clear keeps it set
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               trip_q[g] <= 1'b0;
            end else if (guard_q[g] && peak_s2_q[g] > plevel_q[g]) begin
               trip_q[g] <= 1'b1;
            end else if (soft_rst || (wsel && cmd_we && op == OLTC_OP_CLEAR)) begin
               trip_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // the setting is kept while tripped, so clearing restores it as it was
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_set_v0     <= '0;
         out_set_v1     <= '0;
         crowbar_switch <= 2'b00;
         range_high     <= 2'b00;
      end else begin
         out_set_v0     <= trip_q[0] ? '0 : vimm_q[0];
         out_set_v1     <= trip_q[1] ? '0 : vimm_q[1];
         crowbar_switch <= trip_q;
         range_high     <= range_q;
      end
   end

   // ==========================================================================
   // read data
   logic [1:0]  rid;
   logic [31:0] rd_d;

   assign rid = range_q[sel_q] ? (MODEL_B ? HIGH_RANGE_ID_B : HIGH_RANGE_ID_A)
                               : (MODEL_B ? LOW_RANGE_ID_B : LOW_RANGE_ID_A);

   always_comb begin
      rd_d = 32'h00000000;
      if (hit(haddr[7:0], OFF_CTRL)) begin
         rd_d[CTRL_SEL]    = sel_q;
         rd_d[CTRL_COUPLE] = couple_q;
         rd_d[CTRL_SRCIMM] = srcimm_q;
         rd_d[CTRL_GUARD]  = guard_q[sel_q];
         rd_d[CTRL_RANGE]  = range_q[sel_q];
      end else if (hit(haddr[7:0], OFF_VOLT)) begin
         rd_d[VW-1:0] = vimm_q[sel_q];
      end else if (hit(haddr[7:0], OFF_VTRIG)) begin
         rd_d[VW-1:0] = tprog_q[sel_q] ? vtrig_q[sel_q] : vimm_q[sel_q];
      end else if (hit(haddr[7:0], OFF_STEP)) begin
         rd_d[VW-1:0] = step_q[sel_q];
      end else if (hit(haddr[7:0], OFF_PLEVEL)) begin
         rd_d[VW-1:0] = plevel_q[sel_q];
      end else if (hit(haddr[7:0], OFF_DELAY)) begin
         rd_d[DW-1:0] = delay_q;
      end else if (hit(haddr[7:0], OFF_STAT)) begin
         rd_d[ST_TRIP]             = trip_q[sel_q];
         rd_d[ST_ARMED]            = armed_q;
         rd_d[ST_BUSY]             = busy_q;
         rd_d[ST_OBUFV]            = obuf_v_q;
         rd_d[ST_RID_LO+1:ST_RID_LO] = rid;
      end else if (hit(haddr[7:0], OFF_OBUF)) begin
         rd_d = obuf_q;
      end else if (hit(haddr[7:0], OFF_ESR)) begin
         rd_d[7:0] = esr_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (acc && !hwrite && !stall) begin
         hrdata <= rd_d;
      end
   end
endmodule : oltc_top
`default_nettype wire

// ==== test/oltc_top_checker.sv ====
// checker: port-level properties of the control block
`timescale 1ns/1ps
`default_nettype none
module oltc_top_checker (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [23:0] peak_v0,
   input wire logic [23:0] peak_v1,
   input wire logic [23:0] out_set_v0,
   input wire logic [23:0] out_set_v1,
   input wire logic [1:0]  crowbar_switch,
   input wire logic [1:0]  range_high
);
   import oltc_pkg::*;
   logic        aw_q;
   logic [7:0]  aa_q;
   logic [23:0] lvl_q;
   wire cmd_hit = aw_q && aa_q == OFF_CMD && hready;
   wire rst_hit = cmd_hit && hwdata[3:0] == OLTC_OP_RST;
   wire clr_hit = rst_hit || (cmd_hit && hwdata[3:0] == OLTC_OP_CLEAR);
   wire cfg_hit = rst_hit || (aw_q && aa_q == OFF_CTRL && hready);
   // ==========================================================
   // a stalled data phase keeps its address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aw_q <= 1'b0;
         aa_q <= 8'h00;
      end else if (hready) begin
         aw_q <= hsel && htrans[1] && hwrite;
         aa_q <= haddr[7:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) lvl_q <= PLEVEL_RST;
      else if (rst_hit) lvl_q <= PLEVEL_RST;
      else if (aw_q && aa_q == OFF_PLEVEL && hready) lvl_q <= hwdata[23:0];
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // five cycles covers the two-stage sync plus latch and crowbar stages
   sequence s_over0; (peak_v0 > lvl_q) [*5]; endsequence
   sequence s_over1; (peak_v1 > lvl_q) [*5]; endsequence
   property p_fire0; s_over0 |-> crowbar_switch[0]; endproperty
   property p_fire1; s_over1 |-> crowbar_switch[1]; endproperty
   property p_zero0; $rose(crowbar_switch[0]) |-> ##1 out_set_v0 == 24'h0; endproperty
   property p_zero1; $rose(crowbar_switch[1]) |-> ##1 out_set_v1 == 24'h0; endproperty
   property p_clr0;
      $fell(crowbar_switch[0]) |-> $past(clr_hit) || $past(clr_hit, 2) || $past(clr_hit, 3);
   endproperty
   property p_clr1;
      $fell(crowbar_switch[1]) |-> $past(clr_hit) || $past(clr_hit, 2) || $past(clr_hit, 3);
   endproperty
   property p_range; $changed(range_high) |-> $past(cfg_hit) || $past(cfg_hit, 2); endproperty
   property p_stall; !hreadyout |-> aw_q && aa_q == OFF_CMD; endproperty
   a_fire0: assert property (p_fire0) else $error("crowbar 0 missed");
   a_fire1: assert property (p_fire1) else $error("crowbar 1 missed");
   a_zero0: assert property (p_zero0) else $error("output 0 live when tripped");
   a_zero1: assert property (p_zero1) else $error("output 1 live when tripped");
   a_clr0: assert property (p_clr0) else $error("trip 0 dropped uncommanded");
   a_clr1: assert property (p_clr1) else $error("trip 1 dropped uncommanded");
   a_range: assert property (p_range) else $error("range moved uncommanded");
   a_stall: assert property (p_stall) else $error("stall outside command write");
endmodule : oltc_top_checker
bind oltc_top oltc_top_checker u_oltc_top_checker (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hreadyout, .peak_v0, .peak_v1, .out_set_v0,
   .out_set_v1, .crowbar_switch, .range_high);
`default_nettype wire

// ==== test/oltc_env_model.sv ====
// far-side model: output peak sensing and the group trigger line
`timescale 1ns/1ps
`default_nettype none
module oltc_env_model (
   input wire logic        hclk,
   input wire logic        over,
   input wire logic        fire,
   output logic [23:0]     peak_v0,
   output logic [23:0]     peak_v1,
   output logic            group_trigger
);
   import oltc_pkg::*;
   logic [2:0] cnt_q = 3'h0;
   assign peak_v0 = over ? PLEVEL_RST + 24'h1 : 24'h000100;
   assign peak_v1 = peak_v0;
   // held four cycles so the synchroniser cannot miss it
   always_ff @(posedge hclk) cnt_q <= fire ? 3'h4 : cnt_q - 3'(cnt_q != 3'h0);
   assign group_trigger = cnt_q != 3'h0;
endmodule : oltc_env_model
`default_nettype wire

// ==== test/tb.sv ====
// testbench: register-driven scenarios of the control block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import oltc_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        over = 1'b0;
   logic        fire = 1'b0;
   logic [31:0] hrdata, q;
   logic        hreadyout, hresp, gtrig;
   logic [23:0] pk0, pk1, out0, out1;
   logic [1:0]  crow, rng;
   int          failures = 0;
   int          comparisons = 0;
   int          cyc = 0;
   always #2.5 hclk = ~hclk;
   oltc_top #(.TICK_CYCLES(10)) u_oltc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .group_trigger(gtrig), .peak_v0(pk0), .peak_v1(pk1), .out_set_v0(out0),
      .out_set_v1(out1), .crowbar_switch(crow), .range_high(rng));
   oltc_env_model u_oltc_env_model (.hclk(hclk), .over(over), .fire(fire),
      .peak_v0(pk0), .peak_v1(pk1), .group_trigger(gtrig));
   // ==========================================================
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk
   task automatic bus(input int w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w[0];
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      q = hrdata;
   endtask : bus
   task automatic op(input oltc_op_t o);
      bus(1'b1, OFF_CMD, {28'h0, o});
   endtask : op
   task automatic tk(input int n);
      repeat (n) @(posedge hclk);
   endtask : tk
   task automatic results;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   // ==========================================================
   task automatic t_step;
      bus(0, OFF_CTRL, 0); chk("ctrl", 32'h8, q);
      bus(0, OFF_STEP, 0); chk("step", {8'h0, STEP_DEF}, q);
      bus(0, OFF_DELAY, 0); chk("delay", 32'h0, q);
      bus(1, OFF_VOLT, 32'd100); op(OLTC_OP_UP);
      bus(0, OFF_VOLT, 0); chk("up", 32'd138, q);
      bus(1, OFF_STEP, 32'd5); op(OLTC_OP_DOWN);
      bus(0, OFF_VOLT, 0); chk("down", 32'd133, q);
      op(OLTC_OP_STEPDEF); bus(0, OFF_STEP, 0); chk("stepdef", {8'h0, STEP_DEF}, q);
      op(OLTC_OP_STEPQD); bus(0, OFF_OBUF, 0); chk("stepq", {8'h0, STEP_DEF}, q);
   endtask : t_step
   task automatic t_trig;
      bus(0, OFF_VTRIG, 0); chk("vtrig", 32'd133, q);
      bus(1, OFF_VTRIG, 32'd500); bus(1, OFF_VOLT, 32'd200);
      bus(0, OFF_VTRIG, 0); chk("vtrig", 32'd500, q);
      op(OLTC_OP_TRG); tk(4); chk("unarmed", 32'd200, {8'h0, out0});
      bus(1, OFF_DELAY, 32'd2); op(OLTC_OP_INIT); op(OLTC_OP_TRG);
      tk(15); chk("delaying", 32'd200, {8'h0, out0});
      tk(15); chk("delayed", 32'd500, {8'h0, out0});
      bus(1, OFF_VTRIG, 32'd300); op(OLTC_OP_INIT);
      fire <= 1'b1; tk(1); fire <= 1'b0;
      tk(30); chk("pin", 32'd300, {8'h0, out0});
      op(OLTC_OP_OPCQ); bus(0, OFF_OBUF, 0); chk("opcq", 32'h1, q);
      op(OLTC_OP_OPC); bus(0, OFF_ESR, 0); chk("esr", 32'h1, q);
      bus(1, OFF_CTRL, 32'hc); bus(1, OFF_VTRIG, 32'd700); op(OLTC_OP_INIT);
      tk(3); chk("imm", 32'd700, {8'h0, out0});
   endtask : t_trig
   task automatic t_ovp;
      over <= 1'b1; tk(8); chk("crowbar", 32'h3, {30'h0, crow});
      bus(0, OFF_STAT, 0); chk("tripped", 32'h1, {31'h0, q[0]});
      over <= 1'b0; tk(6);
      op(OLTC_OP_CLEAR); tk(3); chk("cleared", 32'h2, {30'h0, crow});
      chk("restored", 32'd700, {8'h0, out0});
      bus(0, OFF_STAT, 0); chk("untripped", 32'h0, {31'h0, q[0]});
      bus(0, OFF_PLEVEL, 0); chk("plevel", {8'h0, PLEVEL_RST}, q);
   endtask : t_ovp
   task automatic t_range;
      bus(1, OFF_CTRL, 32'h18); tk(2); chk("range", 32'h1, {30'h0, rng});
      bus(0, OFF_STAT, 0); chk("rid", {30'h0, HIGH_RANGE_ID_A}, {30'h0, q[5:4]});
      op(OLTC_OP_DLYMAX); bus(0, OFF_DELAY, 0); chk("dmax", 32'd3600, q);
      op(OLTC_OP_RST); tk(3); chk("rstcrow", 32'h0, {30'h0, crow});
      chk("rstrange", 32'h0, {30'h0, rng});
      bus(0, OFF_CTRL, 0); chk("rstctrl", 32'h8, q);
      bus(0, OFF_DELAY, 0); chk("rstdelay", 32'h0, q);
      bus(0, OFF_STAT, 0); chk("rid", {30'h0, LOW_RANGE_ID_A}, {30'h0, q[5:4]});
      bus(1, OFF_CTRL, 32'h9); bus(1, OFF_VTRIG, 32'd40); bus(1, OFF_DELAY, 32'd1);
      bus(1, OFF_CTRL, 32'ha); op(OLTC_OP_INIT); op(OLTC_OP_TRG); op(OLTC_OP_WAI);
      op(OLTC_OP_DLYMIN); chk("okay", 32'h0, {31'h0, hresp});
      bus(0, OFF_DELAY, 0); chk("dmin", 32'h0, q);
      chk("couple", 32'd40, {8'h0, out1});
   endtask : t_range
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         results();
      end
   end
   initial begin
      tk(5);
      hresetn <= 1'b1;
      t_step();
      t_trig();
      t_ovp();
      t_range();
      results();
   end
endmodule : tb
`default_nettype wire
